// ===== scr_general_config.sv
// Functional notes
// R1 - soft reset bit resets every register
// R2 - soft reset bit clears itself
// R3 - internal reset completes within 750ns
// R4 - host waits out reset before transacting
// R5 - streaming address steps per direction bit
// R6 - separate output flag reads one always
// R7 - no three-wire mode; reads on output
// R8 - power mode: 0 normal, 3 down
// R9 - device power register resets to zero
// R10 - primary register resets to 0x30
// R11 - read-only class code at offset three
// R12 - address hold overrides direction bit
// R13 - serial port works in power down
// R14 - reserved bits reset zero, read back
`timescale 1ns/1ns
module scr_general_config
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// serial register port pins
	input wire logic i_sclk,
	input wire logic i_csb_n,
	input wire logic i_sdi,
	output logic o_sdo,
	// device state
	output logic [1:0] o_power_mode,
	output logic o_power_down,
	output logic o_reset_busy
);
	import scr_pkg::*;

	typedef struct packed
	{
		logic [2:0] sclk_s;
		logic [2:0] csb_s;
		logic [2:0] sdi_s;
		scr_state_t state;
		logic [3:0] hdr_cnt;
		logic [2:0] bit_cnt;
		logic rd;
		logic [14:0] addr;
		logic [7:0] shift;
		logic [7:0] sdo_sh;
		logic sdo;
		logic [7:0] primary;
		logic [7:0] power;
		logic [7:0] class_hi;
		logic [7:0] hold;
		logic [7:0] rst_cnt;
		logic busy;
		logic pd;
	} scr_regs_t;

	scr_regs_t r_reg;
	scr_regs_t r_next;

	logic sclk_rise;
	logic sclk_fall;
	logic cs_act;
	logic [7:0] rd_data;
	logic [7:0] wr_byte;

	// read mux for the current address
	function automatic logic [7:0] read_reg(input scr_regs_t r,
		input logic [14:0] a);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			SCR_OFF_PRIMARY:
			begin
				v = r.primary;
				v[SCR_BIT_SEP_OUT] = 1'b1; // see R6
			end
			SCR_OFF_POWER: v = r.power; // see R14
			SCR_OFF_CLASS: v = {r.class_hi[7:4], SCR_CLASS_CODE}; // see R11
			SCR_OFF_HOLD: v = r.hold;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	always_comb
	begin
		r_next = r_reg;
		r_next.sclk_s = {r_reg.sclk_s[1:0], i_sclk};
		r_next.csb_s = {r_reg.csb_s[1:0], i_csb_n};
		r_next.sdi_s = {r_reg.sdi_s[1:0], i_sdi};
		// edges are taken where stages two and three differ
		sclk_rise = r_reg.sclk_s[1] && !r_reg.sclk_s[2];
		sclk_fall = !r_reg.sclk_s[1] && r_reg.sclk_s[2];
		cs_act = !r_reg.csb_s[1] && !r_reg.csb_s[2];
		rd_data = read_reg(r_reg, r_reg.addr);
		wr_byte = {r_reg.shift[6:0], r_reg.sdi_s[1]};

		if (r_reg.busy)
		begin
			// recovery window: the port is held off, host waits; see R4
			if (r_reg.rst_cnt == SCR_SOFT_RESET_LAST) // see R3
				r_next.busy = 1'b0;
			else
				r_next.rst_cnt = r_reg.rst_cnt + 8'h01;
			r_next.state = SCR_ST_IDLE;
		end
		else if (!cs_act)
		begin
			r_next.state = SCR_ST_IDLE;
			r_next.sdo = 1'b0;
		end
		else
		begin
			// port stays alive in every power mode; see R13
			unique case (r_reg.state)
				SCR_ST_IDLE:
				begin
					r_next.state = SCR_ST_HDR;
					r_next.hdr_cnt = 4'h0;
				end
				SCR_ST_HDR:
				begin
					if (sclk_rise)
					begin
						if (r_reg.hdr_cnt == 4'h0)
							r_next.rd = r_reg.sdi_s[1];
						else
							r_next.addr = {r_reg.addr[13:0], r_reg.sdi_s[1]};
						r_next.hdr_cnt = r_reg.hdr_cnt + 4'h1;
						if (r_reg.hdr_cnt == SCR_HDR_LAST)
						begin
							r_next.state = SCR_ST_DATA;
							r_next.bit_cnt = 3'h0;
						end
					end
				end
				SCR_ST_DATA:
				begin
					// read data leaves only on the separate output; see R7
					if (sclk_fall && r_reg.rd)
					begin
						if (r_reg.bit_cnt == 3'h0)
						begin
							r_next.sdo = rd_data[7];
							r_next.sdo_sh = {rd_data[6:0], 1'b0};
						end
						else
						begin
							r_next.sdo = r_reg.sdo_sh[7];
							r_next.sdo_sh = {r_reg.sdo_sh[6:0], 1'b0};
						end
					end
					if (sclk_rise)
					begin
						r_next.shift = wr_byte;
						r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
						if (r_reg.bit_cnt == SCR_BYTE_LAST)
						begin
							if (!r_reg.rd)
							begin
								unique case (r_reg.addr)
									SCR_OFF_PRIMARY:
									begin
										// flag bits are not storable; see R6
										r_next.primary = (wr_byte & SCR_PRIMARY_WMASK)
											| (r_reg.primary & ~SCR_PRIMARY_WMASK);
										r_next.primary[SCR_BIT_ASCEND] =
											wr_byte[SCR_BIT_ASCEND];
									end
									SCR_OFF_POWER: r_next.power = wr_byte; // see R8
									SCR_OFF_CLASS: r_next.class_hi = wr_byte; // see R14
									SCR_OFF_HOLD: r_next.hold = wr_byte;
									default: r_next.hold = r_reg.hold;
								endcase
							end
							// see R12
							if (r_reg.hold[0])
								r_next.addr = r_reg.addr;
							else if (r_reg.primary[SCR_BIT_ASCEND]) // see R5
								r_next.addr = r_reg.addr + 15'h0001;
							else
								r_next.addr = r_reg.addr - 15'h0001;
						end
					end
				end
				default: r_next.state = SCR_ST_IDLE;
			endcase
			// soft reset: wipe everything, then recover; see R1
			if (!r_reg.rd && sclk_rise && r_reg.state == SCR_ST_DATA
				&& r_reg.bit_cnt == SCR_BYTE_LAST
				&& r_reg.addr == SCR_OFF_PRIMARY
				&& wr_byte[SCR_BIT_SOFT_RESET])
			begin
				r_next.primary = SCR_PRIMARY_RESET; // see R2
				r_next.power = SCR_POWER_RESET;
				r_next.class_hi = SCR_CLASS_RESET;
				r_next.hold = SCR_HOLD_RESET;
				r_next.busy = 1'b1;
				r_next.rst_cnt = 8'h00;
				r_next.state = SCR_ST_IDLE;
				r_next.sdo = 1'b0;
			end
		end
		// decoded ahead so the pin leaves a flop with the mode; see R8
		r_next.pd = (r_next.power[1:0] == SCR_MODE_POWER_DOWN);
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			r_reg <= '0;
			r_reg.sclk_s <= 3'h0;
			r_reg.csb_s <= 3'h7;
			r_reg.state <= SCR_ST_IDLE;
			r_reg.primary <= SCR_PRIMARY_RESET; // see R10
			r_reg.power <= SCR_POWER_RESET; // see R9
			r_reg.class_hi <= SCR_CLASS_RESET;
			r_reg.hold <= SCR_HOLD_RESET;
		end
		else
			r_reg <= r_next;
	end

	// outputs: each a struct field register
	assign o_sdo = r_reg.sdo;
	assign o_power_mode = r_reg.power[1:0];
	assign o_power_down = r_reg.pd;
	assign o_reset_busy = r_reg.busy;
endmodule

// ===== scr_pkg.sv
package scr_pkg;
	// register offsets on the serial register port
	localparam logic [14:0] SCR_OFF_PRIMARY = 15'h0000;
	localparam logic [14:0] SCR_OFF_POWER = 15'h0002;
	localparam logic [14:0] SCR_OFF_CLASS = 15'h0003;
	localparam logic [14:0] SCR_OFF_HOLD = 15'h0010;
	// primary configuration fields
	localparam int SCR_BIT_SOFT_RESET = 7;
	localparam int SCR_BIT_ASCEND = 5;
	localparam int SCR_BIT_SEP_OUT = 4;
	localparam logic [7:0] SCR_PRIMARY_RESET = 8'h30;
	localparam logic [7:0] SCR_PRIMARY_WMASK = 8'h4f;
	// device power configuration fields
	localparam logic [7:0] SCR_POWER_RESET = 8'h00;
	localparam logic [1:0] SCR_MODE_NORMAL = 2'h0;
	localparam logic [1:0] SCR_MODE_POWER_DOWN = 2'h3;
	// converter class code: low nibble fixed, upper nibble read/write
	localparam logic [3:0] SCR_CLASS_CODE = 4'h6; // arbitrary value
	localparam logic [7:0] SCR_CLASS_RESET = 8'h06; // arbitrary low nibble
	localparam logic [7:0] SCR_HOLD_RESET = 8'h00;
	// soft reset recovery window
	localparam int SCR_CLK_MHZ = 250;
	localparam int SCR_SOFT_RESET_NS = 750;
	localparam int SCR_SOFT_RESET_CYC = (SCR_SOFT_RESET_NS * SCR_CLK_MHZ) / 1000;
	localparam logic [7:0] SCR_SOFT_RESET_LAST =
		8'(SCR_SOFT_RESET_CYC - 1);
	// serial frame: r/w bit plus 15 address bits, then data bytes
	localparam logic [3:0] SCR_HDR_LAST = 4'hf;
	localparam logic [2:0] SCR_BYTE_LAST = 3'h7;
	typedef enum logic [2:0]
	{
		SCR_ST_IDLE = 3'b001,
		SCR_ST_HDR = 3'b010,
		SCR_ST_DATA = 3'b100
	} scr_state_t;
endpackage

// ===== scr_general_config_asserts.sv
`timescale 1ns/1ns
module scr_chk
	import scr_pkg::*;
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// serial pins and device state
	input wire logic i_sclk,
	input wire logic i_csb_n,
	input wire logic i_sdi,
	input wire logic o_sdo,
	input wire logic [1:0] o_power_mode,
	input wire logic o_power_down,
	input wire logic o_reset_busy
);
	logic [7:0] n_reg;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	always_ff @(posedge i_mclk)
	begin
		n_reg <= (i_rst || !o_reset_busy) ? 8'h00 : n_reg + 8'h01;
	end
	AST_PD: assert property (o_power_down == (o_power_mode == 2'h3))
		else $error("power down flag wrong");
	AST_RST: assert property ($fell(i_rst) |-> !o_reset_busy
		&& o_power_mode == 2'h0) else $error("reset state wrong");
	AST_IDLE: assert property (i_csb_n [*8] |-> !o_sdo)
		else $error("sdo not idle");
	AST_HOLD: assert property (i_sclk [*4] |-> $stable(o_sdo))
		else $error("sdo moved while sclk high");
	AST_MODE: assert property ($changed(o_power_mode) |-> !i_csb_n
		|| o_reset_busy) else $error("mode changed outside frame");
	AST_BUSY_RISE: assert property ($rose(o_reset_busy) |-> !i_csb_n)
		else $error("busy outside frame");
	AST_BUSY_CLR: assert property (o_reset_busy && $past(o_reset_busy)
		|-> o_power_mode == 2'h0) else $error("mode kept in reset");
	AST_BUSY_MAX: assert property (o_reset_busy |-> n_reg <= 8'hba)
		else $error("busy too long");
	AST_BUSY_END: assert property ($fell(o_reset_busy) |-> n_reg == 8'hbb)
		else $error("busy length wrong");
	cover property ($rose(o_reset_busy));
	cover property (o_power_down);
	cover property (!i_csb_n && o_sdo);
endmodule
bind scr_general_config scr_chk u_chk (.i_mclk(i_mclk), .i_rst(i_rst),
	.i_sclk(i_sclk), .i_csb_n(i_csb_n), .i_sdi(i_sdi), .o_sdo(o_sdo),
	.o_power_mode(o_power_mode), .o_power_down(o_power_down),
	.o_reset_busy(o_reset_busy));

// ===== scr_host.sv
`timescale 1ns/1ns
module scr_host
(
	// clock and serial pins
	input wire logic i_mclk,
	input wire logic i_sdo,
	output logic o_sclk,
	output logic o_csb_n,
	output logic o_sdi
);
	initial
	begin
		o_sclk = 1'b0;
		o_csb_n = 1'b1;
		o_sdi = 1'b0;
	end
	// called at a falling mclk edge; sclk halves of 6 mclk beat the 3 minimum
	task automatic xfer(input logic rd, input logic [14:0] a,
		input logic [15:0] d, input int n, output logic [15:0] q);
		logic [31:0] sh;
		sh = {rd, a, d};
		q = 16'h0000;
		o_csb_n = 1'b0;
		for (int i = 0; i < 16 + 8 * n; i++)
		begin
			o_sdi = sh[31 - i];
			repeat (6) @(negedge i_mclk);
			if (i > 15)
				q = {q[14:0], i_sdo};
			o_sclk = 1'b1;
			repeat (6) @(negedge i_mclk);
			o_sclk = 1'b0;
		end
		repeat (6) @(negedge i_mclk);
		o_csb_n = 1'b1;
		o_sdi = ~o_sdi;
		repeat (6) @(negedge i_mclk);
	endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/1ns
`define CHK(g, e) \
	begin \
		n_tests++; \
		if ((g) !== (e)) \
		begin \
			n_mismatch++; \
			$display("[ERR] %0t got %h exp %h", $time, g, e); \
		end \
	end
module tb_top;
	import scr_pkg::*;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic sclk, csb_n, sdi, sdo, pd, busy;
	logic [1:0] mode;
	logic [15:0] q;
	logic [31:0] seed = 32'ha0cbddcd;
	int n_mismatch = 0;
	int n_tests = 0;
	always #2 i_mclk = ~i_mclk;
	scr_general_config dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_sclk(sclk),
		.i_csb_n(csb_n), .i_sdi(sdi), .o_sdo(sdo), .o_power_mode(mode),
		.o_power_down(pd), .o_reset_busy(busy));
	scr_host host (.i_mclk(i_mclk), .i_sdo(sdo), .o_sclk(sclk),
		.o_csb_n(csb_n), .o_sdi(sdi));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		host.xfer(1'b0, a, {d, 8'h00}, 1, q);
	endtask
	task automatic rd(input logic [14:0] a, input int n);
		host.xfer(1'b1, a, 16'h0000, n, q);
	endtask
	task complete_run;
		if (n_mismatch == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// about 65 frames of under 2 us each, with ample margin
	initial
	begin
		#200000;
		n_mismatch++;
		complete_run();
	end
	initial
	begin
		logic [7:0] d;
		int i;
		repeat (12) @(negedge i_mclk);
		i_rst = 1'b0;
		repeat (4) @(negedge i_mclk);
		rd(SCR_OFF_PRIMARY, 1);
		`CHK(q[7:0], 8'h30)
		rd(SCR_OFF_POWER, 1);
		`CHK(q[7:0], 8'h00)
		rd(SCR_OFF_CLASS, 1);
		`CHK(q[7:0], SCR_CLASS_RESET)
		rd(15'h0001, 1);
		`CHK(q[7:0], 8'h00)
		for (int k = 0; k < 8; k++)
		begin
			d = 8'(rnd());
			wr(SCR_OFF_PRIMARY, {1'b0, d[6:0]});
			rd(SCR_OFF_PRIMARY, 1);
			`CHK(q[7:0], {1'b0, d[6:5], 1'b1, d[3:0]})
			wr(SCR_OFF_POWER, {d[7:2], 2'(k)});
			`CHK(mode, 2'(k))
			`CHK(pd, (k % 4 == 3))
			rd(SCR_OFF_POWER, 1);
			`CHK(q[7:0], {d[7:2], 2'(k)})
			wr(SCR_OFF_CLASS, d);
			rd(SCR_OFF_CLASS, 1);
			`CHK(q[7:0], {d[7:4], SCR_CLASS_CODE})
		end
		wr(SCR_OFF_PRIMARY, 8'h20);
		host.xfer(1'b0, SCR_OFF_POWER, 16'h01a0, 2, q);
		rd(SCR_OFF_POWER, 2);
		`CHK(q, {8'h01, 4'ha, SCR_CLASS_CODE})
		wr(SCR_OFF_PRIMARY, 8'h00);
		host.xfer(1'b0, SCR_OFF_CLASS, 16'h5002, 2, q);
		rd(SCR_OFF_CLASS, 2);
		`CHK(q, {4'h5, SCR_CLASS_CODE, 8'h02})
		wr(SCR_OFF_HOLD, 8'h01);
		rd(SCR_OFF_POWER, 2);
		`CHK(q, 16'h0202)
		wr(SCR_OFF_PRIMARY, 8'h80);
		`CHK(busy, 1'b1)
		`CHK(mode, 2'h0)
		i = 0;
		// no frame may start until recovery ends
		while (busy === 1'b1 && i < 300)
		begin
			@(negedge i_mclk);
			i++;
		end
		`CHK(i < 188, 1'b1)
		rd(SCR_OFF_PRIMARY, 1);
		`CHK(q[7:0], 8'h30)
		rd(SCR_OFF_HOLD, 1);
		`CHK(q[7:0], 8'h00)
		complete_run();
	end
endmodule
